// ==== hdl/rxf_frame_filter.sv ====
// Receive frame type filter and acknowledge pending decision, with AXI4-Lite registers.
// Assumes the receive path drives frame fields in the core_clk domain, one frame at a time.
`default_nettype none
// How it works
// - Reserved types 100 to 111 pass only when accept_reserved_types is set.
// - Command frames 011 pass only when accept_command_frames is set.
// - Acknowledge frames 010 pass only when accept_ack_frames is set.
// - Data frames 001 pass only when accept_payload_frames is set.
// - Beacon frames 000 pass only when accept_beacon_frames is set.
// - Override field keeps, inverts, clears or sets the type MSB before filtering.
// - Altered type feeds the decision only; stored type keeps original bits.
// - Pending set only if all enables, request condition and table hit hold.
// - With pending_needs_data_request set, frame must be a data request command.
// - Source matching is off whenever frame filtering is off.
// - Type control resets to 0x78, source match control to 0x07.
// - With filtering off, every frame passes and no control bit matters.
module rxf_frame_filter
	import rxf_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic frameValid,
	input wire logic [15:0] frameControl,
	input wire logic [SHORT_ADDR_W-1:0] frameSrcAddr,
	input wire logic frameIsDataRequest,
	output logic filterBusy,
	output logic resultValid,
	output logic frameAccept,
	output logic ackPending,
	output logic [2:0] storedType
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rstSync1_r, rstN_r;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rstSync1_r <= 1'b0;
			rstN_r <= 1'b0;
		end else begin
			rstSync1_r <= 1'b1;
			rstN_r <= rstSync1_r;
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic isTable(input logic [9:0] idx);
		return (idx >= IDX_TABLE_BASE) && (idx < IDX_TABLE_BASE + 10'(TABLE_ENTRIES));
	endfunction

	function automatic logic isMapped(input logic [9:0] idx);
		return isTable(idx) || idx == IDX_FILTER_CTRL_ZERO || idx == IDX_FRAME_TYPE_ACCEPT
			|| idx == IDX_SOURCE_MATCH || idx == IDX_SHORT_EN_LOW || idx == IDX_SHORT_EN_MID
			|| idx == IDX_SHORT_EN_HIGH || idx == IDX_SHORT_PEND_LOW
			|| idx == IDX_SHORT_PEND_MID || idx == IDX_SHORT_PEND_HIGH;
	endfunction

	// ****************************************
	// Write channel
	// ****************************************
	logic awHeld_r, wHeld_r;
	logic [9:0] awIdx_r;
	logic [DATA_W-1:0] wData_r;
	logic [3:0] wStrb_r;
	logic doWrite;
	assign doWrite = awHeld_r && wHeld_r && !bvalid;

	always_ff @(posedge core_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			awHeld_r <= 1'b0;
			awready <= 1'b0;
			awIdx_r <= 10'h000;
		end else if (awvalid && awready) begin
			awHeld_r <= 1'b1;
			awready <= 1'b0;
			awIdx_r <= awaddr[ADDR_W-1:2];
		end else if (doWrite) begin
			awHeld_r <= 1'b0;
		end else if (!awHeld_r && !bvalid) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			wHeld_r <= 1'b0;
			wready <= 1'b0;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
		end else if (wvalid && wready) begin
			wHeld_r <= 1'b1;
			wready <= 1'b0;
			wData_r <= wdata;
			wStrb_r <= wstrb;
		end else if (doWrite) begin
			wHeld_r <= 1'b0;
		end else if (!wHeld_r && !bvalid) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp <= isMapped(awIdx_r) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	logic [7:0] filterCtrlZero_r, typeAccept_r, source_match_ctrl_r;
	logic [TABLE_ENTRIES-1:0] shortEnable_r, shortPending_r;
	logic byteWrite;
	assign byteWrite = doWrite && wStrb_r[0];

	// Reserved bits are stored as written; software keeps them zero
	always_ff @(posedge core_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			filterCtrlZero_r <= RST_FILTER_CTRL_ZERO;
			typeAccept_r <= RST_FRAME_TYPE_ACCEPT;
			source_match_ctrl_r <= RST_SOURCE_MATCH;
		end else if (byteWrite) begin
			if (awIdx_r == IDX_FILTER_CTRL_ZERO) begin
				filterCtrlZero_r <= wData_r[7:0];
			end
			if (awIdx_r == IDX_FRAME_TYPE_ACCEPT) begin
				typeAccept_r <= wData_r[7:0];
			end
			if (awIdx_r == IDX_SOURCE_MATCH) begin
				source_match_ctrl_r <= wData_r[7:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			shortEnable_r <= {3{RST_ENABLE_BYTE}};
			shortPending_r <= {3{RST_ENABLE_BYTE}};
		end else if (byteWrite) begin
			unique case (awIdx_r)
				IDX_SHORT_EN_LOW: shortEnable_r[7:0] <= wData_r[7:0];
				IDX_SHORT_EN_MID: shortEnable_r[15:8] <= wData_r[7:0];
				IDX_SHORT_EN_HIGH: shortEnable_r[23:16] <= wData_r[7:0];
				IDX_SHORT_PEND_LOW: shortPending_r[7:0] <= wData_r[7:0];
				IDX_SHORT_PEND_MID: shortPending_r[15:8] <= wData_r[7:0];
				IDX_SHORT_PEND_HIGH: shortPending_r[23:16] <= wData_r[7:0];
				default: ;
			endcase
		end
	end

	// Table words take the low 16 bits; both low byte lanes must be enabled
	logic tblWrEn;
	logic [9:0] tblOffset;
	assign tblOffset = awIdx_r - IDX_TABLE_BASE;
	assign tblWrEn = doWrite && isTable(awIdx_r) && (wStrb_r[1:0] == 2'h3);

	// ****************************************
	// Read channel
	// ****************************************
	function automatic logic [7:0] readByte(input logic [9:0] idx);
		logic [7:0] val;
		val = 8'h00;
		unique case (idx)
			IDX_FILTER_CTRL_ZERO: val = filterCtrlZero_r;
			IDX_FRAME_TYPE_ACCEPT: val = typeAccept_r;
			IDX_SOURCE_MATCH: val = source_match_ctrl_r;
			IDX_SHORT_EN_LOW: val = shortEnable_r[7:0];
			IDX_SHORT_EN_MID: val = shortEnable_r[15:8];
			IDX_SHORT_EN_HIGH: val = shortEnable_r[23:16];
			IDX_SHORT_PEND_LOW: val = shortPending_r[7:0];
			IDX_SHORT_PEND_MID: val = shortPending_r[15:8];
			IDX_SHORT_PEND_HIGH: val = shortPending_r[23:16];
			default: val = 8'h00;
		endcase
		return val;
	endfunction

	logic [9:0] arIdx;
	assign arIdx = araddr[ADDR_W-1:2];

	// Table words read as zero: the read port belongs to the scanner
	always_ff @(posedge core_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h000000, readByte(arIdx)};
			rresp <= isMapped(arIdx) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	// ****************************************
	// Type decision
	// ****************************************
	logic filterOn;
	logic [1:0] override;
	assign filterOn = filterCtrlZero_r[BIT_FILTER_EN];
	assign override = typeAccept_r[BIT_OVERRIDE_HI:BIT_OVERRIDE_LO];

	function automatic logic [2:0] alterType(input logic [2:0] ft, input logic [1:0] mode);
		logic [2:0] res;
		res = ft;
		unique case (mode)
			OVR_KEEP: res = ft;
			OVR_INVERT: res = {~ft[2], ft[1:0]};
			OVR_CLEAR: res = {1'b0, ft[1:0]};
			OVR_SET: res = {1'b1, ft[1:0]};
		endcase
		return res;
	endfunction

	logic [2:0] rawType_r, effType;
	logic typePass;
	assign effType = alterType(rawType_r, override);
	always_comb begin
		if (effType[2]) begin
			typePass = typeAccept_r[BIT_ACCEPT_RESERVED];
		end else begin
			unique case (effType)
				FT_COMMAND: typePass = typeAccept_r[BIT_ACCEPT_COMMAND];
				FT_ACK: typePass = typeAccept_r[BIT_ACCEPT_ACK];
				FT_PAYLOAD: typePass = typeAccept_r[BIT_ACCEPT_PAYLOAD];
				default: typePass = typeAccept_r[BIT_ACCEPT_BEACON];
			endcase
		end
	end

	// ****************************************
	// Source scan
	// ****************************************
	rxf_state_t state_r;
	logic [TABLE_IDX_W-1:0] scanIdx_r, cmpIdx_r;
	logic cmpValid_r, hit_r, cmpHit, dataReq_r;
	logic [SHORT_ADDR_W-1:0] srcAddr_r, tblData;
	logic matchOn, pendNow;

	rxf_short_table u_table (
		.core_clk(core_clk),
		.wrEn(tblWrEn),
		.wrAddr(tblOffset[TABLE_IDX_W-1:0]),
		.wrData(wData_r[SHORT_ADDR_W-1:0]),
		.rdAddr(scanIdx_r),
		.rdData(tblData)
	);

	// Enables are sampled live, so clearing one mid-scan takes effect at once
	assign cmpHit = cmpValid_r && shortEnable_r[cmpIdx_r] && shortPending_r[cmpIdx_r]
		&& (tblData == srcAddr_r);
	assign matchOn = filterOn && source_match_ctrl_r[BIT_SOURCE_MATCH_ENABLE];
	assign pendNow = matchOn && source_match_ctrl_r[BIT_AUTO_PEND]
		&& (!source_match_ctrl_r[BIT_PEND_NEEDS_DREQ] || dataReq_r)
		&& (hit_r || cmpHit);

	always_ff @(posedge core_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			state_r <= RXF_IDLE;
			scanIdx_r <= 5'h00;
		end else begin
			unique case (state_r)
				RXF_IDLE: if (frameValid) begin
					state_r <= RXF_SCAN;
					scanIdx_r <= 5'h00;
				end
				RXF_SCAN: if (scanIdx_r == TABLE_LAST) begin
					state_r <= RXF_FINISH;
				end else begin
					scanIdx_r <= scanIdx_r + 5'h01;
				end
				RXF_FINISH: state_r <= RXF_IDLE;
				default: state_r <= RXF_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			rawType_r <= 3'h0;
			srcAddr_r <= 16'h0000;
			dataReq_r <= 1'b0;
		end else if (state_r == RXF_IDLE && frameValid) begin
			rawType_r <= frameControl[2:0];
			srcAddr_r <= frameSrcAddr;
			dataReq_r <= frameIsDataRequest;
		end
	end

	always_ff @(posedge core_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			cmpValid_r <= 1'b0;
			cmpIdx_r <= 5'h00;
			hit_r <= 1'b0;
		end else begin
			cmpValid_r <= (state_r == RXF_SCAN);
			cmpIdx_r <= scanIdx_r;
			if (state_r == RXF_IDLE) begin
				hit_r <= 1'b0;
			end else if (cmpHit) begin
				hit_r <= 1'b1;
			end
		end
	end

	// ****************************************
	// Results
	// ****************************************
	always_ff @(posedge core_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			resultValid <= 1'b0;
			frameAccept <= 1'b0;
			ackPending <= 1'b0;
			storedType <= 3'h0;
			filterBusy <= 1'b0;
		end else begin
			resultValid <= (state_r == RXF_FINISH);
			filterBusy <= (state_r == RXF_IDLE) ? frameValid : (state_r != RXF_FINISH);
			if (state_r == RXF_FINISH) begin
				frameAccept <= !filterOn || typePass;
				ackPending <= pendNow;
				storedType <= rawType_r;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hdl/rxf_pkg.sv ====
// Constants, register map and state type for the receive frame filter.
// Assumes one core clock and an AXI4-Lite register port with 12-bit byte addresses.
`default_nettype none
package rxf_pkg;
	// ****************************************
	// Bus shape
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Register indices (byte address is four times the index)
	// ****************************************
	localparam logic [9:0] IDX_FILTER_CTRL_ZERO = 10'h000;
	localparam logic [9:0] IDX_FRAME_TYPE_ACCEPT = 10'h001;
	localparam logic [9:0] IDX_SOURCE_MATCH = 10'h002;
	localparam logic [9:0] IDX_SHORT_EN_LOW = 10'h004;
	localparam logic [9:0] IDX_SHORT_EN_MID = 10'h005;
	localparam logic [9:0] IDX_SHORT_EN_HIGH = 10'h006;
	localparam logic [9:0] IDX_SHORT_PEND_LOW = 10'h00C;
	localparam logic [9:0] IDX_SHORT_PEND_MID = 10'h00D;
	localparam logic [9:0] IDX_SHORT_PEND_HIGH = 10'h00E;
	localparam logic [9:0] IDX_TABLE_BASE = 10'h040;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_FILTER_CTRL_ZERO = 8'h0D;
	localparam logic [7:0] RST_FRAME_TYPE_ACCEPT = 8'h78;
	localparam logic [7:0] RST_SOURCE_MATCH = 8'h07;
	localparam logic [7:0] RST_ENABLE_BYTE = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_FILTER_EN = 0;
	localparam int BIT_ACCEPT_RESERVED = 7;
	localparam int BIT_ACCEPT_COMMAND = 6;
	localparam int BIT_ACCEPT_ACK = 5;
	localparam int BIT_ACCEPT_PAYLOAD = 4;
	localparam int BIT_ACCEPT_BEACON = 3;
	localparam int BIT_OVERRIDE_HI = 2;
	localparam int BIT_OVERRIDE_LO = 1;
	localparam int BIT_PEND_NEEDS_DREQ = 2;
	localparam int BIT_AUTO_PEND = 1;
	localparam int BIT_SOURCE_MATCH_ENABLE = 0;

	// ****************************************
	// Frame type codes and override modes
	// ****************************************
	localparam logic [2:0] FT_BEACON = 3'h0;
	localparam logic [2:0] FT_PAYLOAD = 3'h1;
	localparam logic [2:0] FT_ACK = 3'h2;
	localparam logic [2:0] FT_COMMAND = 3'h3;
	localparam logic [1:0] OVR_KEEP = 2'h0;
	localparam logic [1:0] OVR_INVERT = 2'h1;
	localparam logic [1:0] OVR_CLEAR = 2'h2;
	localparam logic [1:0] OVR_SET = 2'h3;

	// ****************************************
	// Short address table
	// ****************************************
	localparam int TABLE_ENTRIES = 24;
	localparam int TABLE_IDX_W = 5;
	localparam int SHORT_ADDR_W = 16;
	localparam logic [4:0] TABLE_LAST = 5'h17;

	typedef enum logic [1:0] {
		RXF_IDLE = 2'b00,
		RXF_SCAN = 2'b01,
		RXF_FINISH = 2'b10
	} rxf_state_t;
endpackage
`default_nettype wire

// ==== hdl/rxf_short_table.sv ====
// Short source address table: 24 words of 16 bits, one write and one read port.
// Assumes writes and reads on the same clock; read data appear one edge after the address.
`default_nettype none
module rxf_short_table
	import rxf_pkg::*;
(
	input wire logic core_clk,
	input wire logic wrEn,
	input wire logic [TABLE_IDX_W-1:0] wrAddr,
	input wire logic [SHORT_ADDR_W-1:0] wrData,
	input wire logic [TABLE_IDX_W-1:0] rdAddr,
	output logic [SHORT_ADDR_W-1:0] rdData
);
	logic [SHORT_ADDR_W-1:0] mem [TABLE_ENTRIES];

	// No reset on the array: contents are software state
	always_ff @(posedge core_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge core_clk) begin
		rdData <= mem[rdAddr];
	end
endmodule
`default_nettype wire

// ==== test/rxf_frame_filter_assertions.sv ====
// Checker for the frame filter: bus handshakes and frame result timing.
// Assumes it is bound to rxf_frame_filter and sees only its ports.
`default_nettype none
module rxf_frame_filter_assertions
	import rxf_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [15:0] frameControl,
	input wire logic filterBusy,
	input wire logic resultValid,
	input wire logic frameAccept,
	input wire logic ackPending,
	input wire logic [2:0] storedType
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	// ****************************************
	// Register bus
	// ****************************************
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_b_done;
		bvalid && bready;
	endsequence
	// Both halves are held one edge before the response is raised
	a_write_answer: assert property (s_wr_taken |-> ##2 bvalid)
		else $error("write response missing");
	a_resp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_ready_return: assert property (s_b_done |=> !awready ##1 (awready && wready))
		else $error("write ready not restored");
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read data missing");
	a_read_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	// ****************************************
	// Frame result
	// ****************************************
	// Scan of 24 entries plus finish gives a fixed latency
	a_result_time: assert property ($rose(filterBusy) |-> ##25 (resultValid && !filterBusy))
		else $error("frame result late");
	a_result_pulse: assert property (resultValid |=> !resultValid)
		else $error("result pulse too long");
	a_type_kept: assert property (
		$rose(filterBusy) |-> ##25 (storedType == $past(frameControl[2:0], 26)))
		else $error("stored type altered");
	a_result_steady: assert property (
		!resultValid |-> $stable({frameAccept, ackPending, storedType}))
		else $error("result changed without pulse");
endmodule
bind rxf_frame_filter rxf_frame_filter_assertions u_rxf_frame_filter_assertions (
	.core_clk, .nrst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rvalid, .rready, .frameControl, .filterBusy,
	.resultValid, .frameAccept, .ackPending, .storedType);
`default_nettype wire

// ==== test/rxf_frame_filter_tb.sv ====
// Testbench for the frame filter: register access and frame decisions.
// Assumes a 100 MHz core clock and the receive path model beside the design.
`default_nettype none
module rxf_frame_filter_tb
	import rxf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, nrst = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [DATA_W-1:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic frameValid, frameIsDataRequest, filterBusy, resultValid, frameAccept, ackPending;
	logic [15:0] frameControl, frameSrcAddr;
	logic [2:0] storedType;
	int mismatches = 0, testsRun = 0, cycleCount = 0;
	logic [9:0] rstIdx[7] = '{10'h000, 10'h001, 10'h002, 10'h004, 10'h005, 10'h006, 10'h00C};
	logic [7:0] rstVal[7] = '{8'h0D, 8'h78, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] pSm[8] = '{8'h07, 8'h07, 8'h03, 8'h03, 8'h03, 8'h01, 8'h02, 8'h03};
	logic [7:0] pF0[8] = '{8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h0C};
	logic [7:0] pEn[8] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h40, 8'h80, 8'h80, 8'h80};
	logic [15:0] pSrc[8] = '{16'hBEEF, 16'hBEEF, 16'hBEEF, 16'hBEEE, 16'hBEEF, 16'hBEEF,
		16'hBEEF, 16'hBEEF};
	logic pDreq[8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
	logic pExp[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

	always #5 core_clk = ~core_clk;

	rxf_frame_filter u_rxf_frame_filter (.core_clk(core_clk), .nrst(nrst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.frameValid(frameValid), .frameControl(frameControl), .frameSrcAddr(frameSrcAddr),
		.frameIsDataRequest(frameIsDataRequest), .filterBusy(filterBusy),
		.resultValid(resultValid), .frameAccept(frameAccept), .ackPending(ackPending),
		.storedType(storedType));
	rxf_rx_path_model u_rxf_rx_path_model (.core_clk(core_clk), .resultValid(resultValid),
		.frameValid(frameValid), .frameControl(frameControl), .frameSrcAddr(frameSrcAddr),
		.frameIsDataRequest(frameIsDataRequest));

	// ****************************************
	// Bus tasks and checks
	// ****************************************
	task automatic wr(input logic [9:0] idx, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge core_clk);
		awaddr <= {idx, 2'b00};
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge core_clk);
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		// Late ready makes the response wait while the checker watches it hold
		repeat (2) @(posedge core_clk);
		bready <= 1'b1;
		do @(posedge core_clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		@(posedge core_clk);
		rready <= 1'b1;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	function automatic logic expAcc(input logic [7:0] ft, input logic [2:0] t);
		logic [2:0] a;
		a = t;
		case (ft[2:1])
			2'h1: a[2] = ~a[2];
			2'h2: a[2] = 1'b0;
			2'h3: a[2] = 1'b1;
			default: a[2] = a[2];
		endcase
		return a[2] ? ft[7] : ft[3 + a[1:0]];
	endfunction
	task automatic finish_test();
		$display("tests_run %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Generous ceiling; the full run needs under 10000 cycles
	always @(posedge core_clk) begin
		cycleCount++;
		if (cycleCount == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] ft;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 7; i++) begin
			rd(rstIdx[i], d, r);
			chk("reset value", {24'h0, rstVal[i]}, d);
		end
		rd(10'h003, d, r);
		chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(10'h003, 32'h0000_00FF, r);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
		// Every accept bit alone and none, under every override mode
		for (int k = 0; k < 6; k++) begin
			for (int o = 0; o < 4; o++) begin
				ft = (k == 5) ? 8'h00 : (8'h08 << k);
				ft[2:1] = o[1:0];
				wr(IDX_FRAME_TYPE_ACCEPT, {24'h0, ft}, r);
				for (int t = 0; t < 8; t++) begin
					u_rxf_rx_path_model.send({13'h1A5A, t[2:0]}, 16'h1234, 1'b0);
					chk("accept", 32'(expAcc(ft, t[2:0])), 32'(frameAccept));
					chk("stored type", 32'(t[2:0]), 32'(storedType));
				end
			end
		end
		rd(IDX_FRAME_TYPE_ACCEPT, d, r);
		chk("type ctrl readback", 32'h0000_0006, d);
		wr(IDX_SHORT_EN_HIGH, 32'h0, r);
		wr(IDX_TABLE_BASE + 10'h017, 32'h0000_BEEF, r);
		wr(IDX_SHORT_PEND_HIGH, 32'h0000_0080, r);
		wr(IDX_FRAME_TYPE_ACCEPT, 32'h0, r);
		for (int i = 0; i < 8; i++) begin
			wr(IDX_SOURCE_MATCH, {24'h0, pSm[i]}, r);
			wr(IDX_FILTER_CTRL_ZERO, {24'h0, pF0[i]}, r);
			wr(IDX_SHORT_EN_HIGH, {24'h0, pEn[i]}, r);
			u_rxf_rx_path_model.send({13'h0, FT_COMMAND}, pSrc[i], pDreq[i]);
			chk("ack pending", 32'(pExp[i]), 32'(ackPending));
			chk("accept no filter", 32'(!pF0[i][0]), 32'(frameAccept));
		end
		// First table entry, reached through the low enable byte
		wr(IDX_TABLE_BASE, 32'h0000_1234, r);
		wr(IDX_SHORT_PEND_LOW, 32'h0000_0001, r);
		wr(IDX_SHORT_EN_LOW, 32'h0000_0001, r);
		wr(IDX_FILTER_CTRL_ZERO, 32'h0000_000D, r);
		rd(IDX_SHORT_EN_LOW, d, r);
		chk("enable low readback", 32'h0000_0001, d);
		u_rxf_rx_path_model.send({13'h0, FT_COMMAND}, 16'h1234, 1'b1);
		chk("first entry pending", 32'h0000_0001, 32'(ackPending));
		finish_test();
	end
endmodule
`default_nettype wire

// ==== test/rxf_rx_path_model.sv ====
// Receive path model: hands one frame to the filter and waits for its result.
// Assumes the filter samples the fields only at the frameValid edge.
`default_nettype none
module rxf_rx_path_model (
	input wire logic core_clk,
	input wire logic resultValid,
	output var logic frameValid,
	output var logic [15:0] frameControl,
	output var logic [15:0] frameSrcAddr,
	output var logic frameIsDataRequest
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		frameValid = 1'b0;
		frameControl = 16'h0000;
		frameSrcAddr = 16'h0000;
		frameIsDataRequest = 1'b0;
	end
	task automatic send(input logic [15:0] ctrl, input logic [15:0] src, input logic dreq);
		@(posedge core_clk);
		frameValid <= 1'b1;
		frameControl <= ctrl;
		frameSrcAddr <= src;
		frameIsDataRequest <= dreq;
		@(posedge core_clk);
		// Fields are stale after the taking edge, so show garbage
		frameValid <= 1'b0;
		frameControl <= ~ctrl;
		frameSrcAddr <= ~src;
		frameIsDataRequest <= ~dreq;
		do @(posedge core_clk); while (resultValid !== 1'b1);
	endtask
endmodule
`default_nettype wire
